// File: udc_defines.vh
// constants shared by the usb device control endpoint logic
`ifndef UDC_DEFINES_VH
`define UDC_DEFINES_VH

// token kinds from the packet layer
`define UDC_KIND_SETUP   2'h0
`define UDC_KIND_OUT     2'h1
`define UDC_KIND_IN      2'h2

// handshake answer codes
`define UDC_RESP_NONE    2'h0
`define UDC_RESP_ACK     2'h1
`define UDC_RESP_NAK     2'h2
`define UDC_RESP_STALL   2'h3

// endpoint 0 control states
`define UDC_ST_IDLE      3'h0
`define UDC_ST_DECODE    3'h1
`define UDC_ST_STAGE     3'h2
`define UDC_ST_STATUS    3'h3
`define UDC_ST_STALL     3'h4

// setup request decoding
`define UDC_RT_STD_DEV_OUT  8'h00
`define UDC_REQ_SET_ADDRESS 8'h05
`define UDC_SETUP_BYTES     4'h8

// reset values
`define UDC_ADDR_RST     7'h00
`define UDC_EN_RST       8'h01

// flag layout: in endpoints low byte, out endpoints high byte
`define UDC_FLAG_OUT_BASE 8

`endif

// File: udc_skid_buf.v
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module udc_skid_buf #(
    parameter W = 9
) (
    // clock and reset
    input  wire         ref_clk,
    input  wire         rst_n,
    // filling side
    input  wire         in_valid,
    input  wire [W-1:0] in_data,
    output reg          in_ready,
    // draining side
    output reg          out_valid,
    output reg  [W-1:0] out_data,
    input  wire         out_ready
);

    reg [W-1:0] spare_reg;
    reg         spare_valid_reg;

    wire take = in_valid && in_ready;
    wire give = out_valid && out_ready;

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_valid       <= 1'b0;
            out_data        <= {W{1'b0}};
            spare_reg       <= {W{1'b0}};
            spare_valid_reg <= 1'b0;
            in_ready        <= 1'b1;
        end
        else
        begin
            if (!out_valid || give)
            begin
                if (spare_valid_reg)
                begin
                    out_data        <= spare_reg;
                    out_valid       <= 1'b1;
                    spare_valid_reg <= take;
                    spare_reg       <= in_data;
                    in_ready        <= 1'b1;
                end
                else
                begin
                    out_valid <= take;
                    out_data  <= in_data;
                end
            end
            else if (take)
            begin
                spare_reg       <= in_data;
                spare_valid_reg <= 1'b1;
                in_ready        <= 1'b0;
            end
        end
    end

endmodule // udc_skid_buf

`default_nettype wire

// File: udc_ep_ctrl.v
// control endpoint and bulk/interrupt endpoint handling
`timescale 1ns/1ps
`default_nettype none
`include "udc_defines.vh"

module udc_ep_ctrl #(
    parameter NEP  = 8,
    parameter AW   = 32,
    parameter CW   = 7
) (
    // clock and reset
    input  wire          ref_clk,
    input  wire          rst_n,
    input  wire          bus_reset,
    // packet layer: tokens, packet end, handshakes
    input  wire          tok_strobe,
    input  wire [1:0]    tok_kind,
    input  wire [2:0]    tok_ep,
    input  wire          pkt_end,
    input  wire          pkt_crc_ok,
    input  wire          pkt_data1,
    input  wire          host_ack,
    output reg           resp_valid,
    output reg  [1:0]    resp_code,
    output reg           resp_data1,
    output reg           resp_zero_len,
    // received byte stream
    input  wire          rx_valid,
    input  wire [7:0]    rx_data,
    output wire          rx_ready,
    output wire          out_data_valid,
    output wire [8:0]    out_data,
    input  wire          out_data_ready,
    // software tasks and controls
    input  wire [NEP-1:0] in_dma_start_task,
    input  wire [NEP-1:0] out_dma_start_task,
    input  wire          control_stall_task,
    input  wire          control_status_stage_task,
    input  wire          control_receive_out_task,
    input  wire          shortcut_done_to_status,
    input  wire          enables_wr,
    input  wire [NEP-1:0] in_endpoint_enables,
    input  wire [NEP-1:0] out_endpoint_enables,
    input  wire          stall_wr,
    input  wire [2:0]    stall_ep,
    input  wire          stall_dir_in,
    input  wire          stall_value,
    input  wire          toggle_wr,
    input  wire [2:0]    toggle_ep,
    input  wire          toggle_dir_in,
    input  wire          toggle_value,
    input  wire [NEP-1:0] out_received_size_wr,
    input  wire [15:0]   capture_flags_clr,
    input  wire [15:0]   data_flags_clr,
    input  wire [2:0]    halt_sel_ep,
    input  wire          halt_sel_in,
    input  wire [AW-1:0] endpoint_buffer_pointer,
    input  wire [CW-1:0] buffer_byte_count,
    // memory transfer engine
    input  wire          dma_done,
    output reg           dma_req,
    output reg           dma_dir_in,
    output reg  [2:0]    dma_ep,
    output reg  [AW-1:0] dma_ptr,
    output reg  [CW-1:0] dma_cnt,
    // events and status
    output reg           setup_received_event,
    output reg  [63:0]   setup_bytes,
    output reg           control_data_done_event,
    output reg           started_event,
    output reg  [NEP-1:0] in_dma_end_event,
    output reg  [NEP-1:0] out_dma_end_event,
    output reg           data_transaction_event,
    output reg  [15:0]   endpoint_capture_flags,
    output reg  [15:0]   data_transaction_flags,
    output reg  [15:0]   halt_status,
    output reg  [6:0]    assigned_device_address,
    output reg           ep0_stalled
);

    reg [2:0]     st_reg;
    reg [1:0]     kind_reg;
    reg [2:0]     ep_reg;
    reg           in_pend_reg;
    reg [2:0]     in_pend_ep_reg;
    reg           setaddr_reg;
    reg [63:0]    shift_reg;
    reg           commit_reg;
    reg [NEP-1:0] in_en_reg;
    reg [NEP-1:0] out_en_reg;
    reg [NEP-1:0] in_full_reg;
    reg [NEP-1:0] out_armed_reg;
    reg [NEP-1:0] in_tog_reg;
    reg [NEP-1:0] out_tog_reg;
    reg [NEP-1:0] in_halt_reg;
    reg [NEP-1:0] out_halt_reg;
    localparam [NEP-1:0] EN_RST = `UDC_EN_RST;

    // ------
    // received bytes, tagged with setup origin
    // ------
    wire is_setup = (kind_reg == `UDC_KIND_SETUP);
    wire head_setup = out_data[8];
    wire drain = out_data_valid && (head_setup || out_data_ready);

    udc_skid_buf #(
        .W (9)
    ) u_rx_buf (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .in_valid  (rx_valid),
        .in_data   ({is_setup, rx_data}),
        .in_ready  (rx_ready),
        .out_valid (out_data_valid),
        .out_data  (out_data),
        .out_ready (head_setup || out_data_ready)
    );

    // ------
    // answer decision
    // ------
    wire       ev_in  = tok_strobe && (tok_kind == `UDC_KIND_IN);
    wire [2:0] ep     = ev_in ? tok_ep : ep_reg;
    wire       ack_in = host_ack && in_pend_reg;
    wire [2:0] aep    = in_pend_ep_reg;
    wire       st0    = (st_reg == `UDC_ST_STATUS);
    reg        rv_n;
    reg [1:0]  rc_n;
    reg        send_n;
    reg        out_new_n;
    reg        setup_n;
    reg        st_out_done_n;

    always @*
    begin
        rv_n = 1'b0;
        rc_n = `UDC_RESP_NONE;
        send_n = 1'b0;
        out_new_n = 1'b0;
        setup_n = 1'b0;
        st_out_done_n = 1'b0;
        if (ev_in && in_en_reg[ep])
        begin
            rv_n = 1'b1;
            rc_n = `UDC_RESP_NAK;
            if (in_halt_reg[ep] || (ep == 3'h0 &&
                st_reg == `UDC_ST_STALL))
                rc_n = `UDC_RESP_STALL;
            else if (ep == 3'h0)
            begin
                // decode state leaves answer at NAK
                if ((st_reg == `UDC_ST_STAGE && in_full_reg[0]) || st0)
                begin
                    rc_n = `UDC_RESP_ACK;
                    send_n = 1'b1;
                end
            end
            else if (in_full_reg[ep])
            begin
                rc_n = `UDC_RESP_ACK;
                send_n = 1'b1;
            end
        end
        else if (pkt_end && is_setup && pkt_crc_ok && ep == 3'h0)
        begin
            rv_n = 1'b1;
            rc_n = `UDC_RESP_ACK;
            setup_n = 1'b1;
        end
        else if (pkt_end && kind_reg == `UDC_KIND_OUT && pkt_crc_ok &&
                 out_en_reg[ep])
        begin
            rv_n = 1'b1;
            rc_n = `UDC_RESP_NAK;
            if (out_halt_reg[ep] || (ep == 3'h0 &&
                st_reg == `UDC_ST_STALL))
                rc_n = `UDC_RESP_STALL;
            else if (ep == 3'h0)
            begin
                if (st_reg == `UDC_ST_STAGE && out_armed_reg[0])
                begin
                    rc_n = `UDC_RESP_ACK;
                    out_new_n = 1'b1;
                end
                else if (st0)
                begin
                    rc_n = `UDC_RESP_ACK;
                    st_out_done_n = 1'b1;
                end
            end
            else if (pkt_data1 != out_tog_reg[ep])
                rc_n = `UDC_RESP_ACK;
            else if (out_armed_reg[ep])
            begin
                rc_n = `UDC_RESP_ACK;
                out_new_n = 1'b1;
            end
        end
    end

    // ------
    // endpoint 0 control state and events
    // ------
    wire st_in_done = ack_in && aep == 3'h0 && st0;
    wire done_now = (out_new_n && ep == 3'h0) ||
                    (ack_in && aep == 3'h0 && !st0);
    wire go_status = control_status_stage_task ||
                     (shortcut_done_to_status && done_now);
    wire commit_now = commit_reg && !(out_data_valid && head_setup);
    wire setaddr = shift_reg[7:0] == `UDC_RT_STD_DEV_OUT &&
                   shift_reg[15:8] == `UDC_REQ_SET_ADDRESS;

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= `UDC_ST_IDLE;
            kind_reg <= `UDC_KIND_IN;
            ep_reg <= 3'h0;
            in_pend_reg <= 1'b0;
            in_pend_ep_reg <= 3'h0;
            setaddr_reg <= 1'b0;
            shift_reg <= 64'h0;
            commit_reg <= 1'b0;
            setup_bytes <= 64'h0;
            setup_received_event <= 1'b0;
            control_data_done_event <= 1'b0;
            assigned_device_address <= `UDC_ADDR_RST;
            resp_valid <= 1'b0;
            resp_code <= `UDC_RESP_NONE;
            resp_data1 <= 1'b0;
            resp_zero_len <= 1'b0;
            ep0_stalled <= 1'b0;
        end
        else
        begin
            resp_valid <= rv_n;
            resp_code <= rc_n;
            resp_data1 <= (ep == 3'h0 && st0) ? 1'b1 : in_tog_reg[ep];
            resp_zero_len <= ep == 3'h0 && st0;
            control_data_done_event <= done_now;
            setup_received_event <= commit_now;
            ep0_stalled <= st_reg == `UDC_ST_STALL;
            if (tok_strobe)
            begin
                kind_reg <= tok_kind;
                ep_reg <= tok_ep;
                in_pend_reg <= send_n;
                in_pend_ep_reg <= tok_ep;
            end
            else if (ack_in)
                in_pend_reg <= 1'b0;
            if (drain && head_setup)
                shift_reg <= {out_data[7:0], shift_reg[63:8]};
            if (setup_n)
                commit_reg <= 1'b1;
            else if (commit_now)
                commit_reg <= 1'b0;
            if (commit_now)
                setup_bytes <= shift_reg;
            if ((st_in_done || st_out_done_n) && setaddr_reg)
                assigned_device_address <= setup_bytes[22:16];
            if (bus_reset)
            begin
                st_reg <= `UDC_ST_IDLE;
                setaddr_reg <= 1'b0;
                assigned_device_address <= `UDC_ADDR_RST;
            end
            else if (setup_n)
            begin
                st_reg <= `UDC_ST_DECODE;
                setaddr_reg <= 1'b0;
            end
            else if (commit_now && setaddr)
            begin
                st_reg <= `UDC_ST_STATUS;
                setaddr_reg <= 1'b1;
            end
            else if (control_stall_task && st_reg != `UDC_ST_IDLE)
                st_reg <= `UDC_ST_STALL;
            else if (st_in_done || st_out_done_n)
                st_reg <= `UDC_ST_IDLE;
            else if (go_status && (st_reg == `UDC_ST_DECODE ||
                     st_reg == `UDC_ST_STAGE))
                st_reg <= `UDC_ST_STATUS;
            else if (st_reg == `UDC_ST_DECODE && (in_dma_start_task[0] ||
                     control_receive_out_task))
                st_reg <= `UDC_ST_STAGE;
        end
    end

    // ------
    // single transfer engine
    // ------
    reg       pick_v;
    reg       pick_in;
    reg [2:0] pick_ep;
    integer   i;

    always @*
    begin
        pick_v = 1'b0;
        pick_in = 1'b0;
        pick_ep = 3'h0;
        for (i = NEP - 1; i >= 0; i = i - 1)
        begin
            if (out_dma_start_task[i])
            begin
                pick_v = 1'b1;
                pick_in = 1'b0;
                pick_ep = i[2:0];
            end
        end
        for (i = NEP - 1; i >= 0; i = i - 1)
        begin
            if (in_dma_start_task[i])
            begin
                pick_v = 1'b1;
                pick_in = 1'b1;
                pick_ep = i[2:0];
            end
        end
    end

    wire start_now = pick_v && !dma_req;
    wire [3:0] start_bit = {~pick_in, pick_ep};
    wire [3:0] end_bit   = {~dma_dir_in, dma_ep};

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dma_req <= 1'b0;
            dma_dir_in <= 1'b0;
            dma_ep <= 3'h0;
            dma_ptr <= {AW{1'b0}};
            dma_cnt <= {CW{1'b0}};
            started_event <= 1'b0;
            in_dma_end_event <= {NEP{1'b0}};
            out_dma_end_event <= {NEP{1'b0}};
            data_transaction_event <= 1'b0;
            endpoint_capture_flags <= 16'h0000;
            data_transaction_flags <= 16'h0000;
            halt_status <= 16'h0000;
        end
        else
        begin
            started_event <= start_now;
            in_dma_end_event <= {NEP{1'b0}};
            out_dma_end_event <= {NEP{1'b0}};
            data_transaction_event <= (out_new_n && ep != 3'h0) ||
                                      (ack_in && aep != 3'h0);
            halt_status <= {15'h0000, halt_sel_in ? in_halt_reg[halt_sel_ep]
                            : out_halt_reg[halt_sel_ep]};
            if (start_now)
            begin
                dma_req <= 1'b1;
                dma_dir_in <= pick_in;
                dma_ep <= pick_ep;
                dma_ptr <= endpoint_buffer_pointer;
                dma_cnt <= buffer_byte_count;
            end
            else if (dma_done && dma_req)
            begin
                dma_req <= 1'b0;
                if (dma_dir_in)
                    in_dma_end_event[dma_ep] <= 1'b1;
                else
                    out_dma_end_event[dma_ep] <= 1'b1;
            end
            // set wins over a clear in the same cycle
            endpoint_capture_flags <= (endpoint_capture_flags &
                ~capture_flags_clr) |
                (start_now ? (16'h0001 << start_bit) : 16'h0000);
            data_transaction_flags <= (data_transaction_flags &
                ~data_flags_clr) |
                ((out_new_n && ep != 3'h0) ? (16'h0100 << ep) : 16'h0000) |
                ((ack_in && aep != 3'h0) ? (16'h0001 << aep) : 16'h0000);
        end
    end

    // ------
    // per-endpoint readiness, toggles, halt and enable
    // ------
    wire in_end  = dma_done && dma_req && dma_dir_in;
    wire out_end = dma_done && dma_req && !dma_dir_in;

    genvar n; // index n serves IN 0x80+n and OUT n
    generate
        for (n = 0; n < NEP; n = n + 1)
        begin : g_ep
            wire zero = (n == 0);
            wire ack_here = ack_in && aep == n && !(zero && st0);
            wire new_here = out_new_n && ep == n;
            wire sel_st = stall_wr && stall_ep == n;
            wire sel_tg = toggle_wr && toggle_ep == n && !zero;
            wire ep0_setup = zero && setup_n;

            always @(posedge ref_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    in_en_reg[n] <= EN_RST[n];
                    out_en_reg[n] <= EN_RST[n];
                    in_full_reg[n] <= 1'b0;
                    out_armed_reg[n] <= 1'b0;
                    in_tog_reg[n] <= 1'b0;
                    out_tog_reg[n] <= 1'b0;
                    in_halt_reg[n] <= 1'b0;
                    out_halt_reg[n] <= 1'b0;
                end
                else if (bus_reset)
                begin
                    in_en_reg[n] <= zero;
                    out_en_reg[n] <= zero;
                    in_full_reg[n] <= 1'b0;
                    out_armed_reg[n] <= 1'b0;
                    in_tog_reg[n] <= 1'b0;
                    out_tog_reg[n] <= 1'b0;
                    in_halt_reg[n] <= 1'b0;
                    out_halt_reg[n] <= 1'b0;
                end
                else
                begin
                    if (enables_wr)
                    begin
                        in_en_reg[n] <= in_endpoint_enables[n];
                        out_en_reg[n] <= out_endpoint_enables[n];
                    end
                    if (ep0_setup)
                    begin
                        in_halt_reg[n] <= 1'b0;
                        out_halt_reg[n] <= 1'b0;
                    end
                    else if (sel_st && stall_dir_in)
                        in_halt_reg[n] <= stall_value;
                    else if (sel_st)
                        out_halt_reg[n] <= stall_value;
                    // toggle per success; forced toggle wins
                    if (ep0_setup)
                        in_tog_reg[n] <= 1'b1;
                    else if (sel_tg && toggle_dir_in)
                        in_tog_reg[n] <= toggle_value;
                    else if (ack_here)
                        in_tog_reg[n] <= ~in_tog_reg[n];
                    if (ep0_setup)
                        out_tog_reg[n] <= 1'b1;
                    else if (sel_tg && !toggle_dir_in)
                        out_tog_reg[n] <= toggle_value;
                    else if (new_here)
                        out_tog_reg[n] <= ~out_tog_reg[n];
                    // empty after the host takes it
                    if (in_end && dma_ep == n)
                        in_full_reg[n] <= 1'b1;
                    else if (ack_here || ep0_setup)
                        in_full_reg[n] <= 1'b0;
                    if (zero ? control_receive_out_task :
                        (out_received_size_wr[n] || (out_end && dma_ep == n)))
                        out_armed_reg[n] <= 1'b1;
                    else if (new_here || ep0_setup || (zero && out_end &&
                             dma_ep == n))
                        out_armed_reg[n] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule // udc_ep_ctrl

`default_nettype wire

// File: udc_ep_ctrl_props.sv
// checker for the usb endpoint control block
`timescale 1ns/1ps
`default_nettype none
`include "udc_defines.vh"
module udc_ep_ctrl_props (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        bus_reset,
    // observed signals
    input wire logic        resp_valid,
    input wire logic [1:0]  resp_code,
    input wire logic        resp_data1,
    input wire logic        resp_zero_len,
    input wire logic [7:0]  in_dma_start_task,
    input wire logic        dma_done,
    input wire logic        dma_req,
    input wire logic        dma_dir_in,
    input wire logic [2:0]  dma_ep,
    input wire logic        started_event,
    input wire logic [7:0]  in_dma_end_event,
    input wire logic [15:0] endpoint_capture_flags,
    input wire logic [15:0] data_transaction_flags,
    input wire logic [15:0] data_flags_clr,
    input wire logic [15:0] halt_status
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_one; resp_valid |=> !resp_valid; endproperty
    a_one: assert property(p_one) else $error("answer longer than one cycle");
    property p_st; in_dma_start_task[0] && !dma_req
        |=> started_event && endpoint_capture_flags[0] && dma_req; endproperty
    a_st: assert property(p_st) else $error("start not taken");
    property p_bz; started_event |-> dma_req; endproperty
    a_bz: assert property(p_bz) else $error("started while idle");
    property p_end; dma_done && dma_req && dma_dir_in && dma_ep == 3'h0
        |=> in_dma_end_event[0] && !dma_req; endproperty
    a_end: assert property(p_end) else $error("no end event");
    property p_stk; data_transaction_flags[9] && !data_flags_clr[9]
        |=> data_transaction_flags[9]; endproperty
    a_stk: assert property(p_stk) else $error("flag lost");
    property p_rst; bus_reset |=> ##1 halt_status == 16'h0000; endproperty
    a_rst: assert property(p_rst) else $error("halt kept");
    property p_fmt; halt_status[15:1] == 15'h0000; endproperty
    a_fmt: assert property(p_fmt) else $error("halt format");
    property p_zl; resp_valid && resp_zero_len
        |-> resp_data1 && resp_code == `UDC_RESP_ACK; endproperty
    a_zl: assert property(p_zl) else $error("bad status answer");
    c_stall: cover property(resp_valid && resp_code == `UDC_RESP_STALL);
    c_zl: cover property(resp_valid && resp_zero_len);
    c_end: cover property(in_dma_end_event[0]);
endmodule // udc_ep_ctrl_props
bind udc_ep_ctrl udc_ep_ctrl_props udc_ep_ctrl_props_i (.*);
`default_nettype wire

// File: udc_host_model.sv
// behavioural usb host on the packet side
`timescale 1ns/1ps
`default_nettype none
module udc_host_model (
    // clock and flow
    input wire logic  ref_clk,
    input wire logic  rx_ready,
    // token, packet and handshake lines
    output logic      tok_strobe,
    output logic [1:0] tok_kind,
    output logic [2:0] tok_ep,
    output logic      pkt_end,
    output logic      pkt_crc_ok,
    output logic      pkt_data1,
    output logic      host_ack,
    output logic      rx_valid,
    output logic [7:0] rx_data
);
    initial {tok_strobe, tok_kind, tok_ep, pkt_end, host_ack, rx_valid} = 0;
    initial {pkt_crc_ok, pkt_data1, rx_data} = 0;
    // packets stay short and word sized
    task automatic snd(input [1:0] k, input [2:0] e, input int n,
                       input [63:0] p, input d1);
        tok_strobe <= 1;
        tok_kind <= k;
        tok_ep <= e;
        @(posedge ref_clk);
        tok_strobe <= 0;
        for (int i = 0; i < n; i++)
        begin
            rx_valid <= 1;
            rx_data <= p[8*i+:8];
            do @(posedge ref_clk); while (!rx_ready);
        end
        rx_valid <= 0;
        rx_data <= ~rx_data;
        if (k != `UDC_KIND_IN)
        begin
            pkt_end <= 1;
            pkt_data1 <= d1;
            pkt_crc_ok <= 1;
            @(posedge ref_clk);
            pkt_end <= 0;
        end
    endtask
    task automatic ack;
        host_ack <= 1;
        @(posedge ref_clk);
        host_ack <= 0;
    endtask
endmodule // udc_host_model
`default_nettype wire

// File: udc_ep_ctrl_bench.sv
// self-checking bench for the usb endpoint control block
`timescale 1ns/1ps
`default_nettype none
`include "udc_defines.vh"
`define CK(a,b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; $display("ERROR %0t value mismatch", $time); end end
`define P(s,v) begin s <= v; @(posedge ref_clk); s <= 0; end
module udc_ep_ctrl_bench;
    logic ref_clk=0, rst_n=0, bus_reset=0, shortcut_done_to_status=0;
    logic control_stall_task=0, control_status_stage_task=0, enables_wr=0;
    logic control_receive_out_task=0, stall_wr=0, stall_dir_in=0;
    logic stall_value=0, toggle_wr=0, toggle_dir_in=0, toggle_value=0;
    logic halt_sel_in=0, dma_done=0, out_data_ready=1;
    logic [2:0] stall_ep=0, toggle_ep=0, halt_sel_ep=0;
    logic [7:0] in_dma_start_task=0, out_dma_start_task=0;
    logic [7:0] in_endpoint_enables=1, out_endpoint_enables=1;
    logic [7:0] out_received_size_wr=0;
    logic [15:0] capture_flags_clr=0, data_flags_clr=0;
    logic [31:0] endpoint_buffer_pointer=32'h0000_0100;
    logic [6:0] buffer_byte_count=7'h40;
    wire tok_strobe, pkt_end, pkt_crc_ok, pkt_data1, host_ack, rx_valid;
    wire rx_ready, resp_valid, resp_data1, resp_zero_len, out_data_valid;
    wire dma_req, dma_dir_in, setup_received_event, control_data_done_event;
    wire started_event, data_transaction_event, ep0_stalled;
    wire [1:0] tok_kind, resp_code;
    wire [2:0] tok_ep, dma_ep;
    wire [7:0] rx_data, in_dma_end_event, out_dma_end_event;
    wire [8:0] out_data;
    wire [31:0] dma_ptr;
    wire [6:0] dma_cnt, assigned_device_address;
    wire [63:0] setup_bytes;
    wire [15:0] endpoint_capture_flags, data_transaction_flags, halt_status;
    int n_mismatch=0, total_checks=0, ne[6];
    logic [3:0] rc;
    wire [5:0] ev = {resp_valid, setup_received_event, control_data_done_event,
                     started_event, data_transaction_event, in_dma_end_event[0]};
    udc_ep_ctrl udc_ep_ctrl_i (.*);
    udc_host_model udc_host_model_i (.*);
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        foreach (ne[i]) ne[i] <= ne[i] + ev[5-i];
        if (resp_valid) rc <= {resp_code, resp_data1, resp_zero_len};
    end
    // one transaction, count of answers and answer code
    task automatic xa(input [1:0] k, input [2:0] e, input [63:0] p,
                      input d1, input int er, input [1:0] ex);
        int b;
        b = ne[0];
        udc_host_model_i.snd(k, e, (k == 0) ? 8 : (k == 1) ? 4 : 0, p, d1);
        repeat (5) @(posedge ref_clk);
        `CK(ne[0] - b, er)
        if (er) `CK(rc[3:2], ex)
    endtask
    task automatic t_ctrl;
        int b;
        b = ne[1];
        xa(0, 0, 64'h0040_0000_0100_0680, 0, 1, `UDC_RESP_ACK);
        `CK(ne[1] - b, 1)
        `CK(setup_bytes, 64'h0040_0000_0100_0680)
        xa(2, 0, 0, 0, 1, `UDC_RESP_NAK);
        b = ne[3];
        `P(in_dma_start_task, 8'h01)
        repeat (2) @(posedge ref_clk);
        `CK(ne[3] - b, 1)
        `CK(endpoint_capture_flags[0], 1'b1)
        b = ne[5];
        `P(dma_done, 1)
        repeat (2) @(posedge ref_clk);
        `CK(ne[5] - b, 1)
        shortcut_done_to_status <= 1;
        b = ne[2];
        xa(2, 0, 0, 0, 1, `UDC_RESP_ACK);
        udc_host_model_i.ack();
        repeat (2) @(posedge ref_clk);
        `CK(ne[2] - b, 1)
        xa(2, 0, 0, 0, 1, `UDC_RESP_ACK);
        `CK(rc[1:0], 2'h3)
        udc_host_model_i.ack();
        xa(0, 0, 64'h0040_0000_0100_0680, 0, 1, `UDC_RESP_ACK);
        `P(control_stall_task, 1)
        xa(2, 0, 0, 0, 1, `UDC_RESP_STALL);
        xa(0, 0, 64'h0000_0000_002A_0500, 0, 1, `UDC_RESP_ACK);
        xa(2, 0, 0, 0, 1, `UDC_RESP_ACK);
        udc_host_model_i.ack();
        repeat (2) @(posedge ref_clk);
        `CK(assigned_device_address, 7'h2A)
        $display("control test done");
    endtask
    task automatic t_bulk;
        int b;
        {in_endpoint_enables, out_endpoint_enables, enables_wr} <= 17'h00607;
        @(posedge ref_clk);
        enables_wr <= 0;
        xa(1, 1, 0, 0, 1, `UDC_RESP_NAK);
        `P(out_received_size_wr, 8'h02)
        b = ne[4];
        xa(1, 1, 0, 0, 1, `UDC_RESP_ACK);
        `CK(ne[4] - b, 1)
        `CK(data_transaction_flags[9], 1'b1)
        xa(1, 1, 0, 1, 1, `UDC_RESP_NAK);
        `P(out_received_size_wr, 8'h02)
        b = ne[4];
        xa(1, 1, 0, 0, 1, `UDC_RESP_ACK);
        `CK(ne[4] - b, 0)
        {stall_wr, stall_ep, stall_value, halt_sel_ep} <= 8'h99;
        @(posedge ref_clk);
        stall_wr <= 0;
        xa(1, 1, 0, 1, 1, `UDC_RESP_STALL);
        `CK(halt_status, 16'h0001)
        `P(bus_reset, 1)
        repeat (2) @(posedge ref_clk);
        `CK(halt_status, 16'h0000)
        xa(1, 1, 0, 0, 0, 0);
        $display("bulk test done");
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1;
        @(posedge ref_clk);
        t_ctrl();
        t_bulk();
        summarize();
    end
    initial
    begin
        #40us;
        n_mismatch++;
        summarize();
    end
endmodule // udc_ep_ctrl_bench
`default_nettype wire
